// ===== design/cc_defines.svh
// register offsets, field positions and reset values of the capture array
// assumes byte addresses on a 32-bit bus, one aligned word per register
`ifndef CC_DEFINES_SVH
`define CC_DEFINES_SVH

`define CC_AW 8
`define CC_NMOD 3
`define CC_WDT_MOD 2
// register map, byte addresses
`define CC_OFS_CTRL 8'h00
`define CC_OFS_AMODE 8'h04
`define CC_OFS_CNTL 8'h08
`define CC_OFS_CNTH 8'h0c
// per-module groups: address bits 7:4 pick the group, 3:2 the module
`define CC_GRP_MODE 4'h1
`define CC_GRP_CPL 4'h2
`define CC_GRP_CPH 4'h3
// control register fields
`define CC_BIT_OVF 7
`define CC_BIT_RUN 6
// array mode register fields
`define CC_BIT_WATCHDOG_ENABLE 6
`define CC_AMODE_RST 8'h40
`define CC_MODE_RST 8'h00
`define CC_BYTE_ZERO 8'h00
`define CC_BYTE_MAX 8'hff
`define CC_WORD_ONE 16'h0001
`define CC_WORD_MAX 16'hffff
`define CC_RESP_OK 2'b00
`define CC_RESP_ERR 2'b10

`endif

// ===== design/cc_pkg.sv
// types shared by the capture/compare array
// assumes cc_defines.svh supplies the numeric constants
package cc_pkg;

    // module mode register, bit 7 down to bit 0
    typedef struct packed {
        logic wide_pwm_select;
        logic comparator_enable;
        logic rising_capture_select;
        logic falling_capture_select;
        logic match_flag_enable;
        logic toggle_enable;
        logic pwm_enable;
        logic module_interrupt_enable;
    } cc_mode_t;

    // decoded operating mode of one module
    typedef enum logic [2:0] {
        CC_OP_CAPTURE = 3'b000,
        CC_OP_TIMER = 3'b001,
        CC_OP_HSO = 3'b010,
        CC_OP_FREQ = 3'b011,
        CC_OP_PWM8 = 3'b100,
        CC_OP_PWM16 = 3'b101
    } cc_op_t;

endpackage

// ===== design/cc_top.sv
// three capture/compare modules on one shared 16-bit counter, AXI4-Lite regs
// assumes one clock, pins asynchronous, counter ticks every enabled cycle
//
// Function
// - capture copies the counter into the compare pair
// - select bits pick rising, falling or either edge
// - capture sets the event flag; only software clears it
// - pin level must hold two cycles to be seen
// - comparator and match enables flag a 16-bit match
// - low byte write clears, high byte write sets comparator
// - toggle mode toggles pin and flags each match
// - disabled comparator holds the toggle pin level
// - frequency mode: low-byte match toggles, adds high byte
// - frequency mode select; half period 0 means 256
// - frequency mode flags a full 16-bit match
// - pwm8: high on low-byte match, low on low wrap
// - pwm8 reloads low byte from high byte on wrap
// - comparator plus pwm is pwm8; flag on 8-bit match
// - pwm8 duty is (256 - high byte)/256
// - pwm16: high on 16-bit match, low on overflow
// - pwm16 flags each match; overflow marks falling edge
// - pwm16 duty is (65536 - compare)/65536
// - comparator off: no toggling, pwm pin held low
// - watchdog enable makes module 2 a watchdog; on at reset
// - mode bits 7..0: wide, cmp, rise, fall, match, tog, pwm, irq
// - counter wrap sets overflow flag until software clears
// - watchdog reset on low wrap while high bytes match
// - module 2 high write loads counter high plus offset
//
// The AXI4-Lite slave port and the register offsets were decided locally.
`timescale 1ns/1ps
`include "cc_defines.svh"

module cc_top
    import cc_pkg::*;
(
    // clock, reset, freeze
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic ce,
    // axi4-lite write address and data
    input wire logic [`CC_AW-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    // axi4-lite write response
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // axi4-lite read
    input wire logic [`CC_AW-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // module pins
    input wire logic [`CC_NMOD-1:0] module_io_pin_i,
    output logic [`CC_NMOD-1:0] module_io_pin_o,
    output logic [`CC_NMOD-1:0] module_io_pin_oe,
    // requests to the system
    output logic [`CC_NMOD-1:0] module_irq,
    output logic watchdog_reset
);

    // bus state
    logic [`CC_AW-1:0] aw_addr_r;
    logic aw_held_r;
    logic [31:0] w_data_r;
    logic w_strb_r;
    logic w_held_r;
    logic bvalid_r;
    logic [1:0] bresp_r;
    logic rvalid_r;
    logic [31:0] rdata_r;
    logic [1:0] rresp_r;
    logic wr_go;
    logic wr_hit;
    logic [7:0] wbyte;

    // counter and array state
    logic [15:0] cnt_r;
    logic [15:0] cnt_nxt;
    logic run_r;
    logic watchdog_enable_r;
    logic ovf_flag_r;
    logic [`CC_NMOD-1:0] event_flag_r;
    logic [`CC_NMOD-1:0] flag_set;
    logic tick;
    logic lo_wrap;
    logic full_wrap;
    logic wr_ctrl;
    logic wr_amode;
    logic wr_cntl;
    logic wr_cnth;
    logic force_wdt;

    // per-module storage
    cc_mode_t mode_r [`CC_NMOD];
    logic [7:0] cmp_lo_r [`CC_NMOD];
    logic [7:0] cmp_hi_r [`CC_NMOD];

    // write handshake: address and data taken in any order
    assign s_axi_awready = ~aw_held_r;
    assign s_axi_wready = ~w_held_r;
    assign s_axi_bvalid = bvalid_r;
    assign s_axi_bresp = bresp_r;
    assign s_axi_arready = ~rvalid_r;
    assign s_axi_rvalid = rvalid_r;
    assign s_axi_rdata = rdata_r;
    assign s_axi_rresp = rresp_r;
    assign wr_go = aw_held_r & w_held_r & ~bvalid_r;
    assign wbyte = w_data_r[7:0];

    // single-register strobes; byte lane 0 carries all register data
    assign wr_ctrl = wr_go & w_strb_r & (aw_addr_r == `CC_OFS_CTRL);
    assign wr_amode = wr_go & w_strb_r & (aw_addr_r == `CC_OFS_AMODE);
    // counter writes are locked out while the watchdog runs
    assign wr_cntl = wr_go & w_strb_r & ~watchdog_enable_r
        & (aw_addr_r == `CC_OFS_CNTL);
    assign wr_cnth = wr_go & w_strb_r & ~watchdog_enable_r
        & (aw_addr_r == `CC_OFS_CNTH);
    assign force_wdt = wr_ctrl & watchdog_enable_r & wbyte[`CC_WDT_MOD];

    // address check for the response code
    always_comb
    begin
        if (aw_addr_r[1:0] != 2'b00)
            wr_hit = 1'b0;
        else if (aw_addr_r[7:4] == 4'h0)
            wr_hit = 1'b1;
        else if ((aw_addr_r[7:4] == `CC_GRP_MODE
                || aw_addr_r[7:4] == `CC_GRP_CPL
                || aw_addr_r[7:4] == `CC_GRP_CPH)
                && aw_addr_r[3:2] < 2'(`CC_NMOD))
            wr_hit = 1'b1;
        else
            wr_hit = 1'b0;
    end

    // write channel capture and response
    always_ff @(posedge clk_sys)
    begin
        if (!rst_n)
        begin
            aw_held_r <= 1'b0;
            aw_addr_r <= '0;
            w_held_r <= 1'b0;
            w_data_r <= '0;
            w_strb_r <= 1'b0;
            bvalid_r <= 1'b0;
            bresp_r <= `CC_RESP_OK;
        end
        else if (ce)
        begin
            if (s_axi_awvalid && !aw_held_r)
            begin
                aw_held_r <= 1'b1;
                aw_addr_r <= s_axi_awaddr;
            end
            if (s_axi_wvalid && !w_held_r)
            begin
                w_held_r <= 1'b1;
                w_data_r <= s_axi_wdata;
                w_strb_r <= s_axi_wstrb[0];
            end
            if (wr_go)
            begin
                aw_held_r <= 1'b0;
                w_held_r <= 1'b0;
                bvalid_r <= 1'b1;
                bresp_r <= wr_hit ? `CC_RESP_OK : `CC_RESP_ERR;
            end
            else if (bvalid_r && s_axi_bready)
                bvalid_r <= 1'b0;
        end
    end

    // read channel: decode and register the answer in one step
    always_ff @(posedge clk_sys)
    begin
        if (!rst_n)
        begin
            rvalid_r <= 1'b0;
            rdata_r <= '0;
            rresp_r <= `CC_RESP_OK;
        end
        else if (ce)
        begin
            if (s_axi_arvalid && !rvalid_r)
            begin
                rvalid_r <= 1'b1;
                rdata_r <= '0;
                rresp_r <= `CC_RESP_OK;
                if (s_axi_araddr == `CC_OFS_CTRL)
                    rdata_r[7:0] <= {ovf_flag_r, run_r, 3'b000,
                        event_flag_r};
                else if (s_axi_araddr == `CC_OFS_AMODE)
                    rdata_r[`CC_BIT_WATCHDOG_ENABLE] <= watchdog_enable_r;
                else if (s_axi_araddr == `CC_OFS_CNTL)
                    rdata_r[7:0] <= cnt_r[7:0];
                else if (s_axi_araddr == `CC_OFS_CNTH)
                    rdata_r[7:0] <= cnt_r[15:8];
                else if (s_axi_araddr[1:0] != 2'b00
                        || s_axi_araddr[3:2] >= 2'(`CC_NMOD))
                    rresp_r <= `CC_RESP_ERR;
                else if (s_axi_araddr[7:4] == `CC_GRP_MODE)
                    rdata_r[7:0] <= mode_r[s_axi_araddr[3:2]];
                else if (s_axi_araddr[7:4] == `CC_GRP_CPL)
                    rdata_r[7:0] <= cmp_lo_r[s_axi_araddr[3:2]];
                else if (s_axi_araddr[7:4] == `CC_GRP_CPH)
                    rdata_r[7:0] <= cmp_hi_r[s_axi_araddr[3:2]];
                else
                    rresp_r <= `CC_RESP_ERR;
            end
            else if (rvalid_r && s_axi_rready)
                rvalid_r <= 1'b0;
        end
    end

    // shared counter; the watchdog forces it to run
    assign tick = run_r | watchdog_enable_r;
    assign cnt_nxt = cnt_r + `CC_WORD_ONE;
    assign lo_wrap = tick & (cnt_r[7:0] == `CC_BYTE_MAX);
    assign full_wrap = tick & (cnt_r == `CC_WORD_MAX);

    always_ff @(posedge clk_sys)
    begin
        if (!rst_n)
            cnt_r <= '0;
        else if (ce)
        begin
            if (wr_cntl)
                cnt_r[7:0] <= wbyte;
            else if (wr_cnth)
                cnt_r[15:8] <= wbyte;
            else if (tick)
                cnt_r <= cnt_nxt;
        end
    end

    // control bits; watchdog comes up enabled
    always_ff @(posedge clk_sys)
    begin
        if (!rst_n)
        begin
            run_r <= 1'b0;
            watchdog_enable_r <= 1'(`CC_AMODE_RST >> `CC_BIT_WATCHDOG_ENABLE);
        end
        else if (ce)
        begin
            if (wr_ctrl)
                run_r <= wbyte[`CC_BIT_RUN];
            if (wr_amode)
                watchdog_enable_r <= wbyte[`CC_BIT_WATCHDOG_ENABLE];
        end
    end

    // sticky flags: writing 0 clears, a set in the same cycle wins
    always_ff @(posedge clk_sys)
    begin
        if (!rst_n)
        begin
            ovf_flag_r <= 1'b0;
            event_flag_r <= '0;
        end
        else if (ce)
        begin
            if (full_wrap)
                ovf_flag_r <= 1'b1;
            else if (wr_ctrl && !wbyte[`CC_BIT_OVF])
                ovf_flag_r <= 1'b0;
            event_flag_r <= flag_set
                | (event_flag_r & ~({`CC_NMOD{wr_ctrl}}
                & ~wbyte[`CC_NMOD-1:0]));
        end
    end

    // watchdog expiry, or a forced one by writing its flag
    always_ff @(posedge clk_sys)
    begin
        if (!rst_n)
            watchdog_reset <= 1'b0;
        else if (ce)
            watchdog_reset <= force_wdt | (watchdog_enable_r & lo_wrap
                & (cmp_hi_r[`CC_WDT_MOD] == cnt_r[15:8]));
    end

    // one identical slice per module
    genvar gi;
    generate
        for (gi = 0; gi < `CC_NMOD; gi++)
        begin : g_mod
            cc_mode_t m;
            cc_op_t op;
            logic wdt_i;
            logic wr_mode;
            logic wr_lo;
            logic wr_hi;
            logic wr_me;
            logic pin_s1_r;
            logic pin_s2_r;
            logic pin_st_r;
            logic pin_flt_r;
            logic cap;
            logic arr16;
            logic arr_lo;
            logic [7:0] pwm_ref;
            logic pin_r;

            assign m = mode_r[gi];
            assign wdt_i = (gi == `CC_WDT_MOD) && watchdog_enable_r;
            assign wr_me = wr_go & w_strb_r & (aw_addr_r[1:0] == 2'b00)
                & (aw_addr_r[3:2] == 2'(gi));
            assign wr_mode = wr_me & (aw_addr_r[7:4] == `CC_GRP_MODE);
            assign wr_lo = wr_me & (aw_addr_r[7:4] == `CC_GRP_CPL);
            assign wr_hi = wr_me & (aw_addr_r[7:4] == `CC_GRP_CPH);

            // mode decode; the watchdog forces software timer
            always_comb
            begin
                if (wdt_i)
                    op = CC_OP_TIMER;
                else if (m.pwm_enable && m.toggle_enable)
                    op = CC_OP_FREQ;
                else if (m.pwm_enable)
                    op = m.wide_pwm_select ? CC_OP_PWM16
                        : CC_OP_PWM8;
                else if (m.toggle_enable)
                    op = CC_OP_HSO;
                else if (m.rising_capture_select
                        || m.falling_capture_select)
                    op = CC_OP_CAPTURE;
                else
                    op = CC_OP_TIMER;
            end

            // two-flop sync, then a level must hold two cycles
            always_ff @(posedge clk_sys)
            begin
                if (!rst_n)
                begin
                    pin_s1_r <= 1'b0;
                    pin_s2_r <= 1'b0;
                    pin_st_r <= 1'b0;
                    pin_flt_r <= 1'b0;
                end
                else if (ce)
                begin
                    pin_s1_r <= module_io_pin_i[gi];
                    pin_s2_r <= pin_s1_r;
                    pin_st_r <= pin_s2_r;
                    if (pin_s2_r == pin_st_r)
                        pin_flt_r <= pin_st_r;
                end
            end

            // accepted edge of the filtered level
            assign cap = (op == CC_OP_CAPTURE) && (pin_s2_r == pin_st_r)
                && (pin_st_r != pin_flt_r)
                && ((m.rising_capture_select && pin_st_r)
                || (m.falling_capture_select && !pin_st_r));

            // matches are taken as the counter arrives at the value
            assign arr16 = tick && (cnt_nxt == {cmp_hi_r[gi], cmp_lo_r[gi]});
            // on a wrap the reloaded byte is the reference
            assign pwm_ref = lo_wrap ? cmp_hi_r[gi] : cmp_lo_r[gi];
            assign arr_lo = tick && (cnt_nxt[7:0] ==
                ((op == CC_OP_PWM8) ? pwm_ref : cmp_lo_r[gi]));

            // event flag sources
            assign flag_set[gi] = cap
                | (m.comparator_enable & m.match_flag_enable & ~wdt_i
                & ((op == CC_OP_PWM8) ? arr_lo : arr16));
            assign module_irq[gi] = event_flag_r[gi]
                & m.module_interrupt_enable;

            // mode register; compare writes steer the comparator enable
            always_ff @(posedge clk_sys)
            begin
                if (!rst_n)
                    mode_r[gi] <= `CC_MODE_RST;
                else if (ce)
                begin
                    if (wr_mode && !wdt_i)
                        mode_r[gi] <= wbyte;
                    else if (wr_lo)
                        mode_r[gi].comparator_enable <= 1'b0;
                    else if (wr_hi)
                        mode_r[gi].comparator_enable <= 1'b1;
                end
            end

            // compare low byte: bus, capture, frequency step, pwm reload
            always_ff @(posedge clk_sys)
            begin
                if (!rst_n)
                    cmp_lo_r[gi] <= `CC_BYTE_ZERO;
                else if (ce)
                begin
                    if (wr_lo)
                        cmp_lo_r[gi] <= wbyte;
                    else if (cap)
                        cmp_lo_r[gi] <= cnt_r[7:0];
                    else if (op == CC_OP_FREQ && m.comparator_enable
                            && arr_lo)
                        cmp_lo_r[gi] <= cmp_lo_r[gi] + cmp_hi_r[gi];
                    else if (op == CC_OP_PWM8 && lo_wrap)
                        cmp_lo_r[gi] <= cmp_hi_r[gi];
                end
            end

            // compare high byte; a watchdog update reloads from counter
            always_ff @(posedge clk_sys)
            begin
                if (!rst_n)
                    cmp_hi_r[gi] <= `CC_BYTE_ZERO;
                else if (ce)
                begin
                    if (wr_hi && wdt_i)
                        cmp_hi_r[gi] <= cnt_r[15:8] + cmp_lo_r[gi];
                    else if (wr_hi)
                        cmp_hi_r[gi] <= wbyte;
                    else if (cap)
                        cmp_hi_r[gi] <= cnt_r[15:8];
                end
            end

            // pin driver; pwm checks set before clear for 100% duty
            always_ff @(posedge clk_sys)
            begin
                if (!rst_n)
                    pin_r <= 1'b0;
                else if (ce)
                begin
                    case (op)
                        CC_OP_HSO:
                            if (m.comparator_enable && arr16)
                                pin_r <= ~pin_r;
                        CC_OP_FREQ:
                            if (m.comparator_enable && arr_lo)
                                pin_r <= ~pin_r;
                        CC_OP_PWM8:
                            if (!m.comparator_enable)
                                pin_r <= 1'b0;
                            else if (arr_lo)
                                pin_r <= 1'b1;
                            else if (lo_wrap)
                                pin_r <= 1'b0;
                        CC_OP_PWM16:
                            if (!m.comparator_enable)
                                pin_r <= 1'b0;
                            else if (arr16)
                                pin_r <= 1'b1;
                            else if (full_wrap)
                                pin_r <= 1'b0;
                        default:
                            pin_r <= pin_r;
                    endcase
                end
            end

            // pin is driven only in the output modes
            assign module_io_pin_o[gi] = pin_r;
            assign module_io_pin_oe[gi] = (op != CC_OP_CAPTURE)
                && (op != CC_OP_TIMER);
        end
    endgenerate

endmodule

// ===== dv/cc_top_monitor.sv
// checker on the capture array ports
// assumes a bind into cc_top
`timescale 1ns/1ps
`include "cc_defines.svh"

module cc_top_monitor
(
    // clock and reset
    input wire logic clk_sys,
    input wire logic rst_n,
    // register bus handshakes
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [31:0] s_axi_rdata,
    // pins and requests
    input wire logic [`CC_NMOD-1:0] module_io_pin_oe,
    input wire logic [`CC_NMOD-1:0] module_irq,
    input wire logic watchdog_reset
);
    default clocking dclk @(posedge clk_sys);
    endclocking
    default disable iff (!rst_n);

    // requests drop only by a write
    chk_irq_sw_clear: assert property (
        |($past(module_irq) & ~module_irq) |-> $rose(s_axi_bvalid))
        else $error("irq fell without write");
    // one cycle, one reset per timeout
    chk_wdt_pulse: assert property (
        watchdog_reset |=> !watchdog_reset)
        else $error("wdt pulse too long");
    // oe follows mode bits set by writes
    chk_oe_by_write: assert property (
        !$stable(module_io_pin_oe) |-> $rose(s_axi_bvalid))
        else $error("oe changed without write");
    chk_reset_quiet: assert property (
        $rose(rst_n) |-> module_io_pin_oe == '0 && module_irq == '0
            && !watchdog_reset)
        else $error("not quiet after reset");
    chk_b_hold: assert property (
        s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
        else $error("b dropped early");
    chk_b_release: assert property (
        s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
        else $error("b repeated");
    chk_r_answer: assert property (
        s_axi_arvalid && !s_axi_rvalid |=> s_axi_rvalid)
        else $error("read answer late");
    chk_r_hold: assert property (
        s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid
            && $stable(s_axi_rdata))
        else $error("r not held");

    // main scenarios reached
    cov_irq: cover property ($rose(module_irq[0]));
    cov_wdt: cover property (watchdog_reset);
    cov_drive: cover property ($rose(module_io_pin_oe[1]));
endmodule

bind cc_top cc_top_monitor u_mon (.clk_sys(clk_sys), .rst_n(rst_n),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready), .s_axi_rdata(s_axi_rdata),
    .module_io_pin_oe(module_io_pin_oe), .module_irq(module_irq),
    .watchdog_reset(watchdog_reset));

// ===== dv/cc_pin_model.sv
// outside circuitry on the module pins
// assumes the design drives a pin only while its enable is high
`timescale 1ns/1ps
`include "cc_defines.svh"

module cc_pin_model
(
    // design side of the pins
    input wire logic [`CC_NMOD-1:0] pin_o,
    input wire logic [`CC_NMOD-1:0] pin_oe,
    // level the outside applies when the design lets go
    input wire logic [`CC_NMOD-1:0] ext_level,
    output logic [`CC_NMOD-1:0] pin_i
);
    // wire level: the driving party wins
    assign pin_i = (pin_o & pin_oe) | (ext_level & ~pin_oe);
endmodule

// ===== dv/tb_top.sv
// self-checking bench for the capture/compare array
// assumes cc_top, the pin model and the bound checker
`timescale 1ns/1ps

module tb_top;
    logic clk_sys, rst_n, ce, awvalid, wvalid, bready, arvalid, rready;
    logic awready, wready, bvalid, arready, rvalid, wdt;
    logic [7:0] awaddr, araddr;
    logic [31:0] wdata, rdata, rd;
    logic [1:0] bresp, rresp, rs;
    logic [2:0] ext, pin_i, pin_o, pin_oe, irq;
    int num_errors, n_compared;

    cc_top dut (.clk_sys(clk_sys), .rst_n(rst_n), .ce(ce),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'h1),
        .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
        .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .module_io_pin_i(pin_i), .module_io_pin_o(pin_o),
        .module_io_pin_oe(pin_oe), .module_irq(irq), .watchdog_reset(wdt));
    cc_pin_model u_pins (.pin_o(pin_o), .pin_oe(pin_oe), .ext_level(ext),
        .pin_i(pin_i));

    // 100 MHz system clock
    initial
    begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end

    task give_verdict();
        $display("errors %0d compared %0d", num_errors, n_compared);
        if (num_errors == 0 && n_compared > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    task chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp)
        begin
            num_errors++;
            $display("Error at %0t: got %h want %h", $time, got, exp);
        end
    endtask

    task stall();
        num_errors++;
        $display("Error at %0t: wait timed out", $time);
        give_verdict();
    endtask

    task tick(input int n);
        repeat (n) @(posedge clk_sys);
    endtask

    // address and data offered together, each released when taken
    task wr(input logic [7:0] a, input logic [7:0] d);
        int n;
        @(posedge clk_sys);
        awaddr <= a;
        wdata <= {24'h0, d};
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        for (n = 0; n < 40 && bvalid !== 1'b1; n++)
        begin
            @(posedge clk_sys);
            if (awvalid && awready)
                awvalid <= 1'b0;
            if (wvalid && wready)
                wvalid <= 1'b0;
        end
        bready <= 1'b0;
        if (n == 40)
            stall();
        chk(bresp, 2'b00);
    endtask

    task rc(input logic [7:0] a, input logic [31:0] e);
        int n;
        @(posedge clk_sys);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        for (n = 0; n < 40 && rvalid !== 1'b1; n++)
        begin
            @(posedge clk_sys);
            if (arvalid && arready)
                arvalid <= 1'b0;
        end
        rd = rdata;
        rs = rresp;
        rready <= 1'b0;
        if (n == 40)
            stall();
        chk(rd, e);
    endtask

    // sel 0..2: module request, 3: watchdog
    task wait_on(input int sel, input int bound, output int n);
        logic [3:0] v;
        for (n = 1; n <= bound; n++)
        begin
            @(posedge clk_sys);
            v = {wdt, irq};
            if (v[sel] === 1'b1)
                return;
        end
        stall();
    endtask

    task count_pin(input int m, input int len, output int hi,
        output int rise);
        logic prev;
        hi = 0;
        rise = 0;
        prev = pin_o[m];
        repeat (len)
        begin
            @(posedge clk_sys);
            hi += (pin_o[m] === 1'b1);
            rise += (pin_o[m] === 1'b1 && prev === 1'b0);
            prev = pin_o[m];
        end
    endtask

    task s_wdt_default();
        int n;
        wait_on(3, 400, n);
        chk(n >= 254 && n <= 258, 1);
    endtask

    task s_regs();
        rc(8'h04, 32'h40);
        rc(8'h10, 32'h0);
        rc(8'hfc, 32'h0);
        chk(rs, 2'b10);
        wr(8'h04, 8'h00);
        rc(8'h04, 32'h0);
    endtask

    // counter stopped so the capture is known
    task automatic s_capture();
        logic [7:0] sel [3] = '{8'h20, 8'h10, 8'h30};
        int i;
        for (i = 0; i < 3; i++)
        begin
            wr(8'h00, 8'h00);
            wr(8'h08, 8'(8'h30 + i));
            wr(8'h0c, 8'h12);
            wr(8'h10, sel[i] | 8'h01);
            ext <= 3'b001;
            tick(8);
            chk(irq[0], sel[i][5]);
            ext <= 3'b000;
            tick(8);
            chk(irq[0], 1'b1);
            rc(8'h20, 32'h30 + i);
            rc(8'h30, 32'h12);
        end
        wr(8'h00, 8'h00);
        chk(irq[0], 1'b0);
        ext <= 3'b001;
        tick(1);
        ext <= 3'b000;
        tick(8);
        chk(irq[0], 1'b0);
    endtask

    task s_match();
        int n;
        wr(8'h00, 8'h00);
        wr(8'h08, 8'hf0);
        wr(8'h0c, 8'h00);
        wr(8'h14, 8'h49);
        wr(8'h18, 8'h4c);
        wr(8'h24, 8'h00);
        rc(8'h14, 32'h09);
        wr(8'h34, 8'h01);
        rc(8'h14, 32'h49);
        wr(8'h28, 8'h00);
        wr(8'h38, 8'h01);
        wr(8'h00, 8'h40);
        wait_on(1, 40, n);
        chk(n >= 10 && n <= 18, 1);
        tick(2);
        chk(pin_o[2], 1'b1);
        rc(8'h00, 32'h46);
        wr(8'h28, 8'h00);
        wr(8'h00, 8'h00);
        wr(8'h08, 8'hf0);
        wr(8'h00, 8'h40);
        tick(30);
        chk(pin_o[2], 1'b1);
    endtask

    // pwm8 and frequency rows over 512 cycles, two pwm8 periods
    task automatic s_wave();
        logic [7:0] md [4] = '{8'h42, 8'h42, 8'h46, 8'h46};
        logic [7:0] hb [4] = '{8'hc0, 8'h00, 8'h10, 8'h00};
        int eh [4] = '{128, 512, 256, 256};
        int er [4] = '{2, 0, 16, 1};
        int i, hi, rise;
        for (i = 0; i < 4; i++)
        begin
            wr(8'h10, md[i]);
            wr(8'h20, 8'h00);
            wr(8'h30, hb[i]);
            tick(600);
            count_pin(0, 512, hi, rise);
            chk(hi, eh[i]);
            chk(rise, er[i]);
        end
        wr(8'h10, 8'h42);
        wr(8'h20, 8'h00);
        tick(300);
        count_pin(0, 512, hi, rise);
        chk(hi, 0);
    endtask

    task s_pwm16();
        int hi, rise;
        wr(8'h00, 8'h00);
        wr(8'h08, 8'h00);
        wr(8'h0c, 8'hfe);
        wr(8'h14, 8'hc2);
        wr(8'h24, 8'h00);
        wr(8'h34, 8'hff);
        wr(8'h00, 8'h40);
        count_pin(1, 600, hi, rise);
        chk(hi, 256);
        chk(rise, 1);
        rc(8'h00, 32'hc0);
    endtask

    task s_watchdog();
        int n;
        wr(8'h28, 8'h01);
        wr(8'h04, 8'h40);
        chk(pin_oe[2], 1'b0);
        wr(8'h38, 8'h00);
        wait_on(3, 700, n);
        chk(n >= 250 && n <= 520, 1);
    endtask

    initial
    begin
        rst_n = 1'b0;
        ce = 1'b1;
        {awvalid, wvalid, bready, arvalid, rready} = 5'h0;
        awaddr = 8'h0;
        araddr = 8'h0;
        wdata = 32'h0;
        ext = 3'h0;
        num_errors = 0;
        n_compared = 0;
        tick(2);
        rst_n <= 1'b1;
        s_wdt_default();
        rst_n <= 1'b0;
        tick(2);
        rst_n <= 1'b1;
        s_regs();
        s_capture();
        s_match();
        s_wave();
        s_pwm16();
        s_watchdog();
        give_verdict();
    end
endmodule
